// ==== inc/ckc_defines.svh ====
`ifndef CKC_DEFINES_SVH
`define CKC_DEFINES_SVH

// ---------------------------------------------------------------
// Register byte offsets (aliases at +4 clear, +8 set, +C invert)
// ---------------------------------------------------------------
`define CKC_OFF_OSC       8'h00
`define CKC_OFF_TRIM      8'h10
`define CKC_OFF_REF       8'h20
`define CKC_OFF_KEY       8'h30

// ---------------------------------------------------------------
// Oscillator control field positions
// ---------------------------------------------------------------
`define CKC_OSC_FAST_RC_DIVIDER    24
`define CKC_OSC_MULT      16
`define CKC_OSC_CUR       12
`define CKC_OSC_REQ       8
`define CKC_OSC_LOCK      7
`define CKC_OSC_USB_PLL_LOCKED     6
`define CKC_OSC_SYS_PLL_LOCKED     5
`define CKC_OSC_SLEEP     4
`define CKC_OSC_FAIL      3
`define CKC_OSC_USBFRC    2
`define CKC_OSC_SOSC      1
`define CKC_OSC_SWREQ     0

// ---------------------------------------------------------------
// Reference clock control field positions
// ---------------------------------------------------------------
`define CKC_REF_DIV       16
`define CKC_REF_EN        15
`define CKC_REF_REFCLK_IDLE_STOP      13
`define CKC_REF_OE        12
`define CKC_REF_REFCLK_RUN_IN_SLEEP      11
`define CKC_REF_DSW       9
`define CKC_REF_ACT       8

// ---------------------------------------------------------------
// Reset values and unlock keys (key values are arbitrary)
// ---------------------------------------------------------------
`define CKC_RST_FAST_RC_DIVIDER    3'h1
`define CKC_KEY_FIRST     32'hC0DE0001
`define CKC_KEY_SECOND    32'hC0DE0002

`endif

// ==== inc/ckc_pkg.sv ====
package ckc_pkg;

  // Switch sequencer states
  typedef enum logic [1:0] {
    CKC_SW_IDLE = 2'b01,
    CKC_SW_BUSY = 2'b10
  } ckc_sw_e;

  // Power modes; WAIT enters Idle or Sleep
  typedef enum logic [2:0] {
    CKC_PM_RUN   = 3'b001,
    CKC_PM_IDLE  = 3'b010,
    CKC_PM_SLEEP = 3'b100
  } ckc_pm_e;

  // Whole block state
  typedef struct packed {
    logic          started;
    logic [1:0]    sw_mon;
    logic [2:0]    pll_mult;
    logic [2:0]    cur_src;
    logic [2:0]    req_src;
    logic [2:0]    frc_div;
    logic          sel_lock;
    logic          sleep_sel;
    logic          fail;
    logic          usb_frc;
    logic          sosc_en;
    logic          sw_req;
    logic [5:0]    trim;
    logic [14:0]   rdiv;
    logic          ren;
    logic          refclk_idle_stop;
    logic          oe;
    logic          refclk_run_in_sleep;
    logic          dsw;
    logic [3:0]    rsel;
    logic [14:0]   act_div;
    logic [14:0]   cnt;
    logic          refclk;
    logic          active;
    logic          unlocked;
    logic          key_seen;
    ckc_sw_e       sw_st;
    ckc_pm_e       pm;
    logic [31:0]   prdata;
    logic          slverr;
  } ckc_state_s;

endpackage

// ==== hdl/ckc_ctrl.sv ====
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "ckc_defines.svh"

// Operation
// - PLL multiplier codes give 15..21, 24
// - Current source field reports source in use
// - Requested source field uses eight source codes
// - Requested source loads from configuration at reset
// - Lock bit freezes selections when monitor 1x
// - USB PLL lock bit reads lock state
// - System PLL lock bit reads lock state
// - Sleep select picks Sleep or Idle on WAIT
// - Clock fail flag set by monitor, read-cleared
// - USB clock select picks fast RC
// - Secondary oscillator enable bit drives oscillator
// - Switch request starts switch, cleared when done
// - Oscillator control and trim writes need unlock sequence
// - Fast RC trim is signed six-bit value
// - Reference output is source over twice divider
// - Reference generator runs only when enabled
// - Stop-in-idle halts reference generator in Idle
// - Output enable drives reference clock pin
// - Run-in-sleep keeps reference; ignored for 0000/0001
// - Divider changes wait for divider switch bit while enabled; immediate when disabled
// - Request status bit shows reference request active
// - Reference source select encodes nine sources
// - Fast RC divider codes; reset divide by two
// - Clear, set and invert aliases per register except the key register

module ckc_ctrl (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Configuration word fields
  input  wire logic [2:0]  cfg_source_default,
  input  wire logic [1:0]  cfg_switch_monitor,
  // Clock system status
  input  wire logic        sys_pll_lock_in,
  input  wire logic        usb_pll_lock_in,
  input  wire logic        usb_pll_enable,
  input  wire logic        failsafe_fail,
  input  wire logic        switch_ready,
  input  wire logic        wait_exec,
  input  wire logic        wake_event,
  input  wire logic [8:0]  ref_src_tick,
  // Clock system controls
  output logic [4:0]       pll_multiplier_factor,
  output logic [2:0]       current_source,
  output logic [8:0]       fast_rc_div_ratio,
  output logic [5:0]       fast_rc_trim_field,
  output logic             usb_fast_rc_select,
  output logic             secondary_osc_enable,
  output logic             switch_busy,
  output logic             sleep_mode,
  output logic             idle_mode,
  // Reference clock
  output logic             refclk_out,
  output logic             refclk_output_pin,
  output logic             refclk_output_pin_oe
);

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------

  // Alias write: 0 direct, 1 clear, 2 set, 3 invert
  function automatic logic [31:0] alias_apply(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [1:0]  sel);
    case (sel)
      2'h1:    alias_apply = old & ~wd;
      2'h2:    alias_apply = old | wd;
      2'h3:    alias_apply = old ^ wd;
      default: alias_apply = wd;
    endcase
  endfunction

  // PLL multiplier code to factor
  function automatic logic [4:0] mult_factor(input logic [2:0] code);
    if (code == 3'h7) begin
      mult_factor = 5'h18;
    end else begin
      mult_factor = 5'h0F + {2'h0, code};
    end
  endfunction

  // Fast RC divider code to ratio
  function automatic logic [8:0] frc_ratio(input logic [2:0] code);
    if (code == 3'h7) begin
      frc_ratio = 9'h100;
    end else begin
      frc_ratio = 9'h001 << code;
    end
  endfunction

  // Oscillator control read image
  function automatic logic [31:0] osc_image(input ckc_pkg::ckc_state_s s,
                                            input logic sl, input logic ul);
    osc_image = 32'h0;
    osc_image[`CKC_OSC_FAST_RC_DIVIDER +: 3] = s.frc_div;
    osc_image[`CKC_OSC_MULT +: 3]   = s.pll_mult;
    osc_image[`CKC_OSC_CUR +: 3]    = s.cur_src;
    osc_image[`CKC_OSC_REQ +: 3]    = s.req_src;
    osc_image[`CKC_OSC_LOCK]        = s.sel_lock;
    osc_image[`CKC_OSC_USB_PLL_LOCKED]       = ul;
    osc_image[`CKC_OSC_SYS_PLL_LOCKED]       = sl;
    osc_image[`CKC_OSC_SLEEP]       = s.sleep_sel;
    osc_image[`CKC_OSC_FAIL]        = s.fail;
    osc_image[`CKC_OSC_USBFRC]      = s.usb_frc;
    osc_image[`CKC_OSC_SOSC]        = s.sosc_en;
    osc_image[`CKC_OSC_SWREQ]       = s.sw_req;
  endfunction

  // Reference control read image
  function automatic logic [31:0] ref_image(input ckc_pkg::ckc_state_s s);
    ref_image = 32'h0;
    ref_image[`CKC_REF_DIV +: 15] = s.rdiv;
    ref_image[`CKC_REF_EN]        = s.ren;
    ref_image[`CKC_REF_REFCLK_IDLE_STOP]      = s.refclk_idle_stop;
    ref_image[`CKC_REF_OE]        = s.oe;
    ref_image[`CKC_REF_REFCLK_RUN_IN_SLEEP]      = s.refclk_run_in_sleep;
    ref_image[`CKC_REF_DSW]       = s.dsw;
    ref_image[`CKC_REF_ACT]       = s.active;
    ref_image[3:0]                = s.rsel;
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  ckc_pkg::ckc_state_s st_ff;    // Registered state
  ckc_pkg::ckc_state_s nxt_st;   // Next state
  logic                setup;    // APB setup phase
  logic                wr;       // APB write access
  logic                rd;       // APB read access
  logic [7:0]          base;     // Register base offset
  logic [1:0]          alias_sel; // Alias selector
  logic                locked;   // Selections frozen
  logic                sys_lk;   // System PLL lock status
  logic                usb_lk;   // USB PLL lock status
  logic                sel_tick; // Selected reference source edge
  logic                running;  // Reference generator running
  logic                wrap;     // Divider terminal count
  logic [31:0]         v;        // Merged write value

  // ---------------------------------------------------------------
  // Decode and status
  // ---------------------------------------------------------------
  assign setup     = psel & ~penable;
  assign wr        = psel & penable & pwrite;
  assign rd        = psel & penable & ~pwrite;
  assign base      = {paddr[7:4], 4'h0};
  assign alias_sel = paddr[3:2];
  assign locked    = st_ff.sw_mon[1] & st_ff.sel_lock;
  assign sys_lk    = sys_pll_lock_in &
                     (st_ff.cur_src == 3'h1 || st_ff.cur_src == 3'h3);
  assign usb_lk    = usb_pll_lock_in & usb_pll_enable;
  assign sel_tick  = (st_ff.rsel <= 4'h8) ? ref_src_tick[st_ff.rsel] : 1'b0;
  assign running   = st_ff.ren &
                     ~(st_ff.pm == ckc_pkg::CKC_PM_IDLE && st_ff.refclk_idle_stop) &
                     ~(st_ff.pm == ckc_pkg::CKC_PM_SLEEP &&
                       ~(st_ff.refclk_run_in_sleep && st_ff.rsel > 4'h1));
  assign wrap      = ({1'b0, st_ff.cnt} + 16'h1) >= {1'b0, st_ff.act_div};

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    v      = 32'h0;
    // Capture configuration after reset release
    if (!st_ff.started) begin
      nxt_st.started = 1'b1;
      nxt_st.req_src = cfg_source_default;
      nxt_st.cur_src = cfg_source_default;
      nxt_st.sw_mon  = cfg_switch_monitor;
    end
    // Read data captured in setup phase
    if (setup) begin
      nxt_st.slverr = 1'b0;
      case (base)
        `CKC_OFF_OSC:  nxt_st.prdata = (alias_sel == 2'h0) ?
                                       osc_image(st_ff, sys_lk, usb_lk) : 32'h0;
        `CKC_OFF_TRIM: nxt_st.prdata = (alias_sel == 2'h0) ?
                                       {26'h0, st_ff.trim} : 32'h0;
        `CKC_OFF_REF:  nxt_st.prdata = (alias_sel == 2'h0) ? ref_image(st_ff) : 32'h0;
        `CKC_OFF_KEY:  nxt_st.prdata = {31'h0, st_ff.unlocked};
        default: begin
          nxt_st.prdata = 32'h0;
          nxt_st.slverr = 1'b1;
        end
      endcase
    end
    // Clock switch sequencer
    case (st_ff.sw_st)
      ckc_pkg::CKC_SW_IDLE: begin
        if (st_ff.sw_req) begin
          nxt_st.sw_st = ckc_pkg::CKC_SW_BUSY;
        end
      end
      ckc_pkg::CKC_SW_BUSY: begin
        if (switch_ready) begin
          nxt_st.cur_src = st_ff.req_src;
          nxt_st.sw_req  = 1'b0;
          nxt_st.sw_st   = ckc_pkg::CKC_SW_IDLE;
        end
      end
      default: nxt_st.sw_st = ckc_pkg::CKC_SW_IDLE;
    endcase
    // Read of control register clears fail flag
    if (rd && base == `CKC_OFF_OSC && alias_sel == 2'h0) begin
      nxt_st.fail = 1'b0;
    end
    // Unlock key register
    if (wr && base == `CKC_OFF_KEY) begin
      nxt_st.key_seen = (pwdata == `CKC_KEY_FIRST);
      nxt_st.unlocked = st_ff.key_seen && (pwdata == `CKC_KEY_SECOND);
    end
    // Oscillator control write
    if (wr && base == `CKC_OFF_OSC && st_ff.unlocked) begin
      v = alias_apply(osc_image(st_ff, sys_lk, usb_lk), pwdata, alias_sel);
      if (!locked) begin
        nxt_st.frc_div  = v[`CKC_OSC_FAST_RC_DIVIDER +: 3];
        nxt_st.pll_mult = v[`CKC_OSC_MULT +: 3];
        nxt_st.req_src  = v[`CKC_OSC_REQ +: 3];
        nxt_st.sel_lock = v[`CKC_OSC_LOCK];
        nxt_st.sw_req   = v[`CKC_OSC_SWREQ];
      end
      nxt_st.sleep_sel = v[`CKC_OSC_SLEEP];
      nxt_st.fail      = v[`CKC_OSC_FAIL];
      nxt_st.usb_frc   = v[`CKC_OSC_USBFRC];
      nxt_st.sosc_en   = v[`CKC_OSC_SOSC];
    end
    // Monitor event wins over any clear
    if (failsafe_fail) begin
      nxt_st.fail = 1'b1;
    end
    // Fast RC trim write
    if (wr && base == `CKC_OFF_TRIM && st_ff.unlocked) begin
      v = alias_apply({26'h0, st_ff.trim}, pwdata, alias_sel);
      nxt_st.trim = v[5:0];
    end
    // Power mode on WAIT and wake
    case (st_ff.pm)
      ckc_pkg::CKC_PM_RUN: begin
        if (wait_exec) begin
          nxt_st.pm = st_ff.sleep_sel ? ckc_pkg::CKC_PM_SLEEP
                                      : ckc_pkg::CKC_PM_IDLE;
        end
      end
      ckc_pkg::CKC_PM_IDLE, ckc_pkg::CKC_PM_SLEEP: begin
        if (wake_event) begin
          nxt_st.pm = ckc_pkg::CKC_PM_RUN;
        end
      end
      default: nxt_st.pm = ckc_pkg::CKC_PM_RUN;
    endcase
    // Reference divider: half period of act_div source edges
    nxt_st.active = running;
    if (!running) begin
      nxt_st.refclk = 1'b0;
      nxt_st.cnt    = 15'h0;
    end else if (sel_tick) begin
      if (st_ff.act_div == 15'h0) begin
        nxt_st.refclk = 1'b1;
      end else if (wrap) begin
        nxt_st.refclk = ~st_ff.refclk;
        nxt_st.cnt    = 15'h0;
      end else begin
        nxt_st.cnt = st_ff.cnt + 15'h1;
      end
    end else if (st_ff.act_div == 15'h0) begin
      nxt_st.refclk = 1'b0;
    end
    // Divider switch: immediate when off, at a half period when on
    if (!st_ff.ren) begin
      nxt_st.act_div = st_ff.rdiv;
      nxt_st.dsw     = 1'b0;
    end else if (st_ff.dsw && (!running || (sel_tick && (wrap || st_ff.act_div == 15'h0)))) begin
      nxt_st.act_div = st_ff.rdiv;
      nxt_st.cnt     = 15'h0;
      nxt_st.dsw     = 1'b0;
    end
    // Reference control write
    if (wr && base == `CKC_OFF_REF) begin
      v = alias_apply(ref_image(st_ff), pwdata, alias_sel);
      nxt_st.rdiv = v[`CKC_REF_DIV +: 15];
      nxt_st.ren  = v[`CKC_REF_EN];
      nxt_st.refclk_idle_stop = v[`CKC_REF_REFCLK_IDLE_STOP];
      nxt_st.oe   = v[`CKC_REF_OE];
      nxt_st.refclk_run_in_sleep = v[`CKC_REF_REFCLK_RUN_IN_SLEEP];
      nxt_st.rsel = v[3:0];
      if (v[`CKC_REF_DSW]) begin
        nxt_st.dsw = 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff         <= '0;
      st_ff.frc_div <= `CKC_RST_FAST_RC_DIVIDER;
      st_ff.sw_st   <= ckc_pkg::CKC_SW_IDLE;
      st_ff.pm      <= ckc_pkg::CKC_PM_RUN;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign pready                = 1'b1;
  assign prdata                = st_ff.prdata;
  assign pslverr               = st_ff.slverr;
  assign pll_multiplier_factor = mult_factor(st_ff.pll_mult);
  assign current_source        = st_ff.cur_src;
  assign fast_rc_div_ratio     = frc_ratio(st_ff.frc_div);
  assign fast_rc_trim_field    = st_ff.trim;
  assign usb_fast_rc_select    = st_ff.usb_frc;
  assign secondary_osc_enable  = st_ff.sosc_en;
  assign switch_busy           = (st_ff.sw_st == ckc_pkg::CKC_SW_BUSY);
  assign sleep_mode            = (st_ff.pm == ckc_pkg::CKC_PM_SLEEP);
  assign idle_mode             = (st_ff.pm == ckc_pkg::CKC_PM_IDLE);
  assign refclk_out            = st_ff.refclk;
  assign refclk_output_pin     = st_ff.refclk & st_ff.oe;
  assign refclk_output_pin_oe  = st_ff.oe;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_switch_done_copy: assert property (
    st_ff.sw_st == ckc_pkg::CKC_SW_BUSY && switch_ready &&
    !(wr && base == `CKC_OFF_OSC)
    |=> !st_ff.sw_req && st_ff.cur_src == $past(st_ff.req_src))
    else $error("switch completion did not update source");

  a_fail_flag_set: assert property (
    failsafe_fail |=> st_ff.fail)
    else $error("clock fail event lost");

  a_mult_factor_top: assert property (
    st_ff.pll_mult == 3'h7 |-> pll_multiplier_factor == 5'h18)
    else $error("multiplier code 7 not 24");

  a_lock_freeze_sel: assert property (
    locked |=> $stable(st_ff.req_src) && $stable(st_ff.pll_mult))
    else $error("locked selection changed");

  a_unlock_trim_guard: assert property (
    !st_ff.unlocked |=> $stable(st_ff.trim))
    else $error("trim changed while locked");

  a_ref_disabled_low: assert property (
    !st_ff.ren |=> !st_ff.refclk && !st_ff.active)
    else $error("reference ran while disabled");

  a_pin_gated_off: assert property (
    !st_ff.oe |-> !refclk_output_pin)
    else $error("pin driven with output disabled");

  a_idle_stop_ref: assert property (
    idle_mode && st_ff.refclk_idle_stop |=> !st_ff.refclk)
    else $error("reference ran in idle with stop set");

  a_wait_to_sleep: assert property (
    st_ff.pm == ckc_pkg::CKC_PM_RUN && wait_exec && st_ff.sleep_sel |=> sleep_mode)
    else $error("wait did not enter sleep");

endmodule

// ==== tb/clock_source_and_refclk_control_tb.sv ====
`timescale 1ns/1ps
`include "ckc_defines.svh"

`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin miscompares++; \
  $display("[FAIL] %s exp %0h got %0h", nm, ex, gt); end end

module clock_source_and_refclk_control_tb;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] cfg_src, cur_src;
  logic [1:0] cfg_mon;
  logic sys_lk, usb_lk, usb_en, fs_fail, sw_rdy, wait_x, wake;
  logic [8:0] ticks, frc_ratio;
  logic [4:0] mult;
  logic [5:0] trim;
  logic usb_frc, sosc, busy, slp, idl, rclk, rpin, rpin_oe;
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;

  ckc_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .cfg_source_default(cfg_src), .cfg_switch_monitor(cfg_mon),
    .sys_pll_lock_in(sys_lk), .usb_pll_lock_in(usb_lk), .usb_pll_enable(usb_en),
    .failsafe_fail(fs_fail), .switch_ready(sw_rdy), .wait_exec(wait_x), .wake_event(wake),
    .ref_src_tick(ticks), .pll_multiplier_factor(mult), .current_source(cur_src),
    .fast_rc_div_ratio(frc_ratio), .fast_rc_trim_field(trim), .usb_fast_rc_select(usb_frc),
    .secondary_osc_enable(sosc), .switch_busy(busy), .sleep_mode(slp), .idle_mode(idl),
    .refclk_out(rclk), .refclk_output_pin(rpin), .refclk_output_pin_oe(rpin_oe));

  // Clock of 25 ns period
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // Hang guard
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      summarize();
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  // One APB transfer; waits for pready at the access edge
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  // One-cycle pulse: 0 wait, 1 wake, 2 switch ready, 3 clock fail
  task automatic pulse(input int which);
    @(posedge pclk);
    case (which)
      0: wait_x <= 1'b1;
      1: wake <= 1'b1;
      2: sw_rdy <= 1'b1;
      default: fs_fail <= 1'b1;
    endcase
    @(posedge pclk);
    {wait_x, wake, sw_rdy, fs_fail} <= 4'h0;
    @(negedge pclk);
  endtask

  // Mid-run reset with selections lockable, then lock and try a change
  task automatic t_lock();
    @(posedge pclk);
    presetn <= 1'b0;
    cfg_mon <= 2'h2;
    cfg_src <= 3'h4;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    `CHK("cfg source", 3'h4, cur_src)
    apb(8'h30, 1'b1, `CKC_KEY_FIRST);
    apb(8'h30, 1'b1, `CKC_KEY_SECOND);
    apb(8'h00, 1'b1, 32'h01000380);
    apb(8'h00, 1'b1, 32'h01000500);
    apb(8'h00, 1'b0, 32'h0);
    `CHK("locked req", 3'h3, rd[10:8])
    `CHK("lock bit", 1'b1, rd[7])
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset_and_lock_trim();
    apb(8'h00, 1'b0, 32'h0);
    `CHK("osc ctl reset", 32'h01003360, rd)
    `CHK("frc ratio", 9'd2, frc_ratio)
    apb(8'h10, 1'b1, 32'h20);
    apb(8'h10, 1'b0, 32'h0);
    `CHK("trim locked", 32'h0, rd)
    apb(8'h30, 1'b1, `CKC_KEY_FIRST);
    apb(8'h30, 1'b1, `CKC_KEY_SECOND);
    apb(8'h10, 1'b1, 32'h20);
    apb(8'h10, 1'b0, 32'h0);
    `CHK("trim min", 32'h20, rd)
    `CHK("trim out", 6'h20, trim)
  endtask

  task automatic t_multiplier();
    logic [4:0] fac [8] = '{5'd15, 5'd16, 5'd17, 5'd18, 5'd19, 5'd20, 5'd21, 5'd24};
    for (int i = 0; i < 8; i++) begin
      apb(8'h00, 1'b1, 32'h01000300 | (i << 16));
      @(negedge pclk);
      `CHK("mult factor", fac[i], mult)
    end
  endtask

  task automatic t_alias_and_power();
    apb(8'h08, 1'b1, 32'h16);
    @(negedge pclk);
    `CHK("sosc set", 1'b1, sosc)
    `CHK("usb frc set", 1'b1, usb_frc)
    apb(8'h04, 1'b1, 32'h02);
    apb(8'h0C, 1'b1, 32'h04);
    @(negedge pclk);
    `CHK("sosc clr", 1'b0, sosc)
    `CHK("usb frc inv", 1'b0, usb_frc)
    pulse(0);
    `CHK("sleep on wait", 2'b10, {slp, idl})
    pulse(1);
    apb(8'h04, 1'b1, 32'h10);
    pulse(0);
    `CHK("idle on wait", 2'b01, {slp, idl})
    pulse(1);
  endtask

  task automatic t_switch_and_fail();
    apb(8'h00, 1'b1, 32'h01000201);
    repeat (2) @(negedge pclk);
    `CHK("busy", 1'b1, busy)
    `CHK("cur held", 3'h3, cur_src)
    pulse(2);
    `CHK("cur new", 3'h2, cur_src)
    apb(8'h00, 1'b0, 32'h0);
    `CHK("swreq done", 1'b0, rd[0])
    pulse(3);
    apb(8'h00, 1'b0, 32'h0);
    `CHK("fail set", 1'b1, rd[3])
    apb(8'h00, 1'b0, 32'h0);
    `CHK("fail clr", 1'b0, rd[3])
  endtask

  task automatic t_refclk();
    int chg;
    logic prev;
    apb(8'h20, 1'b1, 32'h00011000);
    apb(8'h20, 1'b1, 32'h00019000);
    ticks[0] <= 1'b1;
    repeat (4) @(negedge pclk);
    prev = rpin;
    chg = 0;
    for (int i = 0; i < 8; i++) begin
      @(negedge pclk);
      if (rpin !== prev) chg++;
      prev = rpin;
    end
    `CHK("ref toggles", 8, chg)
    `CHK("ref oe", 1'b1, rpin_oe)
    apb(8'h20, 1'b1, 32'h00029000);
    chg = 0;
    for (int i = 0; i < 8; i++) begin
      @(negedge pclk);
      if (rpin !== prev) chg++;
      prev = rpin;
    end
    `CHK("div held", 8, chg)
    apb(8'h20, 1'b1, 32'h00029200);
    repeat (4) @(negedge pclk);
    prev = rpin;
    chg = 0;
    for (int i = 0; i < 8; i++) begin
      @(negedge pclk);
      if (rpin !== prev) chg++;
      prev = rpin;
    end
    `CHK("div switched", 4, chg)
    apb(8'h20, 1'b0, 32'h0);
    `CHK("div sw done", 1'b0, rd[9])
    `CHK("ref active bit", 1'b1, rd[8])
    apb(8'h20, 1'b1, 32'h00018000);
    repeat (3) @(negedge pclk);
    `CHK("pin off", 2'b00, {rpin, rpin_oe})
    apb(8'h20, 1'b1, 32'h0);
    repeat (3) @(negedge pclk);
    `CHK("ref off", 1'b0, rclk)
    ticks <= '0;
    apb(8'h40, 1'b0, 32'h0);
    `CHK("unmapped err", 1'b1, pslverr)
  endtask

  // ----------------------------------------
  // Verdict
  // ----------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; cfg_src = 3'h3; cfg_mon = 2'h0;
    sys_lk = 1'b1; usb_lk = 1'b1; usb_en = 1'b1; fs_fail = 1'b0;
    sw_rdy = 1'b0; wait_x = 1'b0; wake = 1'b0; ticks = 9'h000;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    t_reset_and_lock_trim();
    t_multiplier();
    t_alias_and_power();
    t_switch_and_fail();
    t_refclk();
    t_lock();
    summarize();
  end
endmodule
